// ==== hdl/rmg_router.sv ====
// MIDI port router and merger with beat clock tempo tracking
`timescale 1ns/100ps
module rmg_router #(
  parameter logic [31:0] TEMPO_LOSS = rmg_pkg::TEMPO_LOSS_CYC
) (
  input  wire logic                                   clk_sys,
  input  wire logic                                   arst_n,
  input  wire logic                                   ce,
  input  wire logic                                   thru_on,
  input  wire logic                                   usb_adapter_on,
  input  wire logic                                   int_dump,
  input  wire logic                                   int_dump_usb,
  input  wire rmg_pkg::rmg_strm_t [rmg_pkg::NSRC-1:0] src_in,
  output logic                    [rmg_pkg::NSRC-1:0] src_ready,
  output rmg_pkg::rmg_strm_t      [rmg_pkg::NDST-1:0] dst_out,
  input  wire logic               [rmg_pkg::NDST-1:0] dst_ready,
  output logic                    [31:0]              beat_interval,
  output logic                                        tempo_sync
);
  import rmg_pkg::*;

  typedef enum logic [1:0] {
    ST_OPEN   = 2'b01,
    ST_LOCKED = 2'b10
  } rmg_state_t;

  rmg_state_t               state_q, state_d;
  logic [1:0]               owner_q, owner_d;
  logic [NDST-1:0]          mask [NSRC];
  logic [NSRC-1:0]          msg_end;
  logic [NDST-1:0]          room, load;
  logic [1:0]               pick;
  logic                     pick_vld, fire;
  logic [7:0]               pick_byte;
  rmg_strm_t [NDST-1:0]     out_q, out_d;
  logic [31:0]              cnt_q, cnt_d, ival_q, ival_d;
  logic                     seen_q, seen_d, sync_q, sync_d;

  // Destination masks per source; dumps pick one port only
  always_comb begin
    for (int i = 0; i < NSRC; i++) mask[i] = '0;
    if (int_dump) begin
      mask[SRC_INT][DST_USB] = int_dump_usb;
      mask[SRC_INT][DST_SER] = !int_dump_usb;
    end else begin
      mask[SRC_INT][DST_SER]  = 1'b1;
      mask[SRC_INT][DST_RET]  = 1'b1;
      mask[SRC_INT][DST_FOOT] = 1'b1;
      mask[SRC_INT][DST_USB]  = 1'b1;
    end
    mask[SRC_USB][DST_PROC]  = 1'b1;
    mask[SRC_SER][DST_PROC]  = 1'b1;
    mask[SRC_FOOT][DST_PROC] = 1'b1;
    mask[SRC_SER][DST_SER]   = thru_on;
    mask[SRC_FOOT][DST_SER]  = thru_on;
    // Both bridge directions share one setting
    mask[SRC_USB][DST_SER]   = usb_adapter_on;
    mask[SRC_SER][DST_USB]   = usb_adapter_on;
    mask[SRC_FOOT][DST_USB]  = usb_adapter_on;
  end

  // Boundary trackers, one per source
  for (genvar g = 0; g < NSRC; g++) begin : g_trk
    rmg_msg_track u_trk (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .ce      (ce),
      .byte_i  (src_in[g].data),
      .take    (fire && pick == 2'(g)),
      .msg_end (msg_end[g])
    );
  end

  // Pick a source: real-time bytes cut in, else owner, else priority
  always_comb begin
    pick     = 2'(SRC_INT);
    pick_vld = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (src_in[i].valid && state_q == ST_OPEN) begin
        pick     = 2'(i);
        pick_vld = 1'b1;
      end
    end
    if (state_q == ST_LOCKED && src_in[owner_q].valid) begin
      pick     = owner_q;
      pick_vld = 1'b1;
    end
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (src_in[i].valid && rmg_is_rt(src_in[i].data)) begin
        pick     = 2'(i);
        pick_vld = 1'b1;
      end
    end
    pick_byte = src_in[pick].data;
  end

  // A byte moves only when every wanted output has room
  always_comb begin
    for (int d = 0; d < NDST; d++)
      room[d] = !out_q[d].valid || dst_ready[d];
    fire = ce && pick_vld && ((mask[pick] & ~room) == '0);
    load = fire ? mask[pick] : '0;
    for (int i = 0; i < NSRC; i++)
      src_ready[i] = fire && pick == 2'(i);
  end

  // Lock on a message start, release on its last byte
  always_comb begin
    state_d = state_q;
    owner_d = owner_q;
    case (state_q)
      ST_OPEN: begin
        if (fire && !rmg_is_rt(pick_byte) && !msg_end[pick]) begin
          state_d = ST_LOCKED;
          owner_d = pick;
        end
      end
      ST_LOCKED: begin
        if (fire && pick == owner_q && !rmg_is_rt(pick_byte)
            && msg_end[pick])
          state_d = ST_OPEN;
      end
      default: state_d = ST_OPEN;
    endcase
  end

  // Output holding registers, one byte each
  always_comb begin
    for (int d = 0; d < NDST; d++) begin
      out_d[d] = out_q[d];
      if (load[d]) begin
        out_d[d].valid = 1'b1;
        out_d[d].data  = pick_byte;
      end else if (dst_ready[d]) begin
        out_d[d].valid = 1'b0;
      end
    end
  end

  // Beat clock interval; sync drops when clocks stop arriving
  always_comb begin
    cnt_d  = (cnt_q == TEMPO_LOSS) ? cnt_q : cnt_q + 32'h1;
    ival_d = ival_q;
    seen_d = seen_q;
    sync_d = sync_q;
    if (cnt_q == TEMPO_LOSS) begin
      seen_d = 1'b0;
      sync_d = 1'b0;
    end
    if (load[DST_PROC] && pick_byte == BYTE_BEAT_CLK) begin
      cnt_d  = CNT_RST;
      seen_d = 1'b1;
      if (seen_q && cnt_q != TEMPO_LOSS) begin
        ival_d = cnt_q + 32'h1;
        sync_d = 1'b1;
      end
    end
  end

  // Register all state, frozen while ce is low
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_OPEN;
      owner_q <= 2'h0;
      out_q   <= '0;
      cnt_q   <= CNT_RST;
      ival_q  <= CNT_RST;
      seen_q  <= 1'b0;
      sync_q  <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      owner_q <= owner_d;
      out_q   <= out_d;
      cnt_q   <= cnt_d;
      ival_q  <= ival_d;
      seen_q  <= seen_d;
      sync_q  <= sync_d;
    end
  end

  assign dst_out       = out_q;
  assign beat_interval = ival_q;
  assign tempo_sync    = sync_q;

  // Checks on routing, locking and tempo
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_int_fanout: assert property (
    fire && pick == 2'(SRC_INT) && !int_dump |=>
      out_q[DST_SER].valid && out_q[DST_RET].valid &&
      out_q[DST_FOOT].valid && out_q[DST_USB].valid &&
      out_q[DST_USB].data == $past(pick_byte))
    else $error("internal byte missed an output");
  a_dump_single: assert property (
    fire && pick == 2'(SRC_INT) && int_dump |->
      (load[DST_SER] ^ load[DST_USB]) && !load[DST_RET])
    else $error("dump not sent to exactly one port");
  a_proc_always: assert property (
    fire && pick != 2'(SRC_INT) |=>
      out_q[DST_PROC].valid && out_q[DST_PROC].data == $past(pick_byte))
    else $error("input byte not given to processor");
  a_thru_copy: assert property (
    fire && (pick == 2'(SRC_SER) || pick == 2'(SRC_FOOT)) |->
      load[DST_SER] == thru_on)
    else $error("serial out copy disagrees with settings");
  a_bridge_pair: assert property (
    fire && pick != 2'(SRC_INT) && !usb_adapter_on |->
      !load[DST_USB] && (pick != 2'(SRC_USB) || !load[DST_SER]))
    else $error("bridge path open with adapter off");
  a_host_to_ser: assert property (
    fire && pick == 2'(SRC_USB) && usb_adapter_on |->
      load[DST_SER] ##1 out_q[DST_SER].data == $past(pick_byte))
    else $error("host byte not forwarded to serial out");
  a_in_to_host: assert property (
    fire && pick >= 2'(SRC_SER) && usb_adapter_on |-> load[DST_USB])
    else $error("input byte not forwarded to host");
  a_tempo_track: assert property (
    ce && load[DST_PROC] && pick_byte == BYTE_BEAT_CLK && seen_q &&
      cnt_q != TEMPO_LOSS |=> ival_q == $past(cnt_q) + 32'h1 && sync_q)
    else $error("beat interval not captured");
  a_no_interleave: assert property (
    state_q == ST_LOCKED && fire && !rmg_is_rt(pick_byte) |->
      pick == owner_q)
    else $error("bytes of two messages interleaved");

  c_locked_msg:  cover property (state_q == ST_OPEN ##1 state_q == ST_LOCKED
    ##[1:20] state_q == ST_OPEN);
  c_rt_cut_in:   cover property (state_q == ST_LOCKED && fire &&
    pick != owner_q);
  c_tempo_sync:  cover property ($rose(sync_q));
  c_out_stall:   cover property (fire == 1'b0 && pick_vld && ce);

endmodule // rmg_router

// ==== hdl/rmg_pkg.sv ====
// Shared types, constants and decode functions for the MIDI router/merger
package rmg_pkg;

  // One byte slot of a MIDI byte stream
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rmg_strm_t;

  // Source indices, lowest index wins arbitration
  localparam int NSRC     = 4;
  localparam int SRC_INT  = 0;  // Internally generated messages
  localparam int SRC_USB  = 1;  // Host USB output stream
  localparam int SRC_SER  = 2;  // Serial input port
  localparam int SRC_FOOT = 3;  // Foot controller port

  // Destination indices
  localparam int NDST     = 5;
  localparam int DST_SER  = 0;  // Serial output port
  localparam int DST_RET  = 1;  // Return pins of bidirectional input
  localparam int DST_FOOT = 2;  // Foot controller port
  localparam int DST_USB  = 3;  // Host USB input stream
  localparam int DST_PROC = 4;  // Internal message processor

  // Byte classes
  localparam logic [7:0] BYTE_RT_MIN    = 8'hf8;
  localparam logic [7:0] BYTE_BEAT_CLK  = 8'hf8;
  localparam logic [7:0] BYTE_SYSEX_GO  = 8'hf0;
  localparam logic [7:0] BYTE_SYSEX_END = 8'hf7;

  // Beat clock loss time and derived cycle count
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          TEMPO_LOSS_MS = 200;
  localparam logic [31:0] TEMPO_LOSS_CYC =
    32'(TEMPO_LOSS_MS * (CLK_HZ / 1000));
  localparam int          TEMPO_CNT_W   = 32;

  // Reset values
  localparam logic [1:0]  LEFT_RST = 2'h0;
  localparam logic [31:0] CNT_RST  = 32'h0;

  // Real-time single-byte message
  function automatic logic rmg_is_rt(input logic [7:0] b);
    return b >= BYTE_RT_MIN;
  endfunction

  // Data bytes that follow a status byte
  function automatic logic [1:0] rmg_data_len(input logic [7:0] b);
    logic [1:0] len;
    len = 2'h0;
    case (b[7:4])
      4'h8, 4'h9, 4'ha, 4'hb, 4'he: len = 2'h2;
      4'hc, 4'hd:                   len = 2'h1;
      4'hf: begin
        if (b == 8'hf1 || b == 8'hf3) len = 2'h1;
        else if (b == 8'hf2)          len = 2'h2;
      end
      default:                      len = 2'h0;
    endcase
    return len;
  endfunction

endpackage

// ==== hdl/rmg_msg_track.sv ====
// Per-source MIDI message boundary tracker
`timescale 1ns/100ps
module rmg_msg_track (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic [7:0] byte_i,
  input  wire logic       take,
  output logic            msg_end
);
  import rmg_pkg::*;

  logic [1:0] left_q, left_d;
  logic [1:0] run_len_q, run_len_d;
  logic       sysex_q, sysex_d;

  // Decode whether this byte closes a message
  always_comb begin
    left_d    = left_q;
    run_len_d = run_len_q;
    sysex_d   = sysex_q;
    msg_end   = 1'b0;
    if (rmg_is_rt(byte_i)) begin
      msg_end = 1'b0;                 // Never moves the boundary
    end else if (byte_i == BYTE_SYSEX_GO) begin
      sysex_d   = 1'b1;
      run_len_d = 2'h0;
    end else if (byte_i == BYTE_SYSEX_END) begin
      sysex_d   = 1'b0;
      msg_end   = 1'b1;
    end else if (byte_i[7]) begin
      sysex_d   = 1'b0;
      left_d    = rmg_data_len(byte_i);
      // System common cancels running status
      run_len_d = (byte_i[7:4] == 4'hf) ? 2'h0 : rmg_data_len(byte_i);
      msg_end   = (rmg_data_len(byte_i) == 2'h0);
    end else if (sysex_q) begin
      msg_end = 1'b0;
    end else if (left_q != 2'h0) begin
      left_d  = left_q - 2'h1;
      msg_end = (left_q == 2'h1);
    end else if (run_len_q != 2'h0) begin
      left_d  = run_len_q - 2'h1;     // Running status restarts count
      msg_end = (run_len_q == 2'h1);
    end else begin
      msg_end = 1'b1;                 // Stray data byte stands alone
    end
  end

  // Register only on an accepted byte
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      left_q    <= LEFT_RST;
      run_len_q <= LEFT_RST;
      sysex_q   <= 1'b0;
    end else if (ce && take) begin
      left_q    <= left_d;
      run_len_q <= run_len_d;
      sysex_q   <= sysex_d;
    end
  end

endmodule // rmg_msg_track

// ==== verif/rmg_sink_model.sv ====
// Far-side sink model taking bytes from every router destination
`timescale 1ns/100ps
module rmg_sink_model (
  input  wire logic                     clk_sys,
  input  wire logic                     arst_n,
  input  wire logic                     slow,
  output logic      [rmg_pkg::NDST-1:0] dst_ready
);
  import rmg_pkg::*;
  logic [1:0] ph_q;
  logic [1:0] ph_d;

  // Phase counter; staggered stalls over three phases, so sinks 0 and 3, and 1 and 4, act in lockstep
  always_comb begin
    ph_d = (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) ph_q <= 2'h0;
    else ph_q <= ph_d;
  end

  // Slow mode: each sink ready one cycle in three
  always_comb begin
    for (int d = 0; d < NDST; d++)
      dst_ready[d] = !slow || (ph_q == 2'(d % 3));
  end
endmodule // rmg_sink_model

// ==== verif/testbench.sv ====
// Self-checking testbench for the MIDI router and merger
`timescale 1ns/100ps
module testbench;
  import rmg_pkg::*;
  localparam logic [31:0] TL = 32'h0000_00c8;
  logic                 clk_sys, arst_n, ce, thru_on, usb_adapter_on;
  logic                 int_dump, int_dump_usb, slow, any_v;
  rmg_strm_t [NSRC-1:0] src_in;
  logic      [NSRC-1:0] src_ready;
  rmg_strm_t [NDST-1:0] dst_out;
  logic      [NDST-1:0] dst_ready;
  logic      [31:0]     beat_interval;
  logic                 tempo_sync;
  logic      [7:0]      got[NDST][$];
  int                   n_fail, num_checks, cyc, tk, t1;

  rmg_router #(.TEMPO_LOSS(TL)) i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .ce(ce), .thru_on(thru_on), .usb_adapter_on(usb_adapter_on),
    .int_dump(int_dump), .int_dump_usb(int_dump_usb), .src_in(src_in),
    .src_ready(src_ready), .dst_out(dst_out), .dst_ready(dst_ready),
    .beat_interval(beat_interval), .tempo_sync(tempo_sync));
  rmg_sink_model i_sink (.clk_sys(clk_sys), .arst_n(arst_n), .slow(slow),
    .dst_ready(dst_ready));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Capture every byte a sink accepts; cycle count for tempo timing
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    for (int d = 0; d < NDST; d++)
      if (dst_out[d].valid === 1'b1 && dst_ready[d] === 1'b1)
        got[d].push_back(dst_out[d].data);
  end
  always_comb begin
    any_v = 1'b0;
    for (int d = 0; d < NDST; d++) any_v |= dst_out[d].valid;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Compare a sink's bytes with a message, or with nothing when off
  task automatic cmp_q(input int d, input logic [7:0] e[$], input bit on);
    check($sformatf("count dst%0d", d), got[d].size(), on ? e.size() : 0);
    if (on && got[d].size() == e.size())
      foreach (e[i]) check($sformatf("byte dst%0d", d), got[d][i], e[i]);
  endtask

  task automatic clr;
    foreach (got[d]) got[d].delete();
  endtask

  // Valid stays up across a message so no edge sees a gap
  task automatic send_msg(input int s, input logic [7:0] m[$]);
    int n;
    foreach (m[i]) begin
      src_in[s] <= {1'b1, m[i]};
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (src_ready[s] !== 1'b1 && n < 200);
      if (n >= 200) check("source taken", 32'h0, 32'h1);
      tk = cyc;
    end
    src_in[s] <= '0;
  endtask

  task automatic drain;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (any_v !== 1'b0 && n < 100);
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic t_internal;
    slow <= 1'b1;
    clr;
    send_msg(SRC_INT, '{8'h90, 8'h3c, 8'h7f});
    drain;
    for (int d = DST_SER; d <= DST_USB; d++)
      cmp_q(d, '{8'h90, 8'h3c, 8'h7f}, 1);
    slow <= 1'b0;
    $display("test internal broadcast done");
  endtask

  task automatic t_dump;
    int_dump <= 1'b1;
    for (int u = 0; u < 2; u++) begin
      int_dump_usb <= u[0];
      clr;
      send_msg(SRC_INT, '{8'hb0, 8'h07, 8'h01});
      drain;
      cmp_q(DST_SER, '{8'hb0, 8'h07, 8'h01}, u == 0);
      cmp_q(DST_USB, '{8'hb0, 8'h07, 8'h01}, u == 1);
      cmp_q(DST_RET, '{8'hb0}, 0);
    end
    int_dump <= 1'b0;
    $display("test bulk dump done");
  endtask

  // Modes: 0 plain, 1 thru, 2 adapter; every external source in each
  task automatic t_paths;
    for (int md = 0; md < 3; md++)
      for (int s = SRC_USB; s <= SRC_FOOT; s++) begin
        thru_on <= (md == 1);
        usb_adapter_on <= (md == 2);
        clr;
        send_msg(s, '{8'hc0, 8'h05});
        drain;
        cmp_q(DST_PROC, '{8'hc0, 8'h05}, 1);
        cmp_q(DST_SER, '{8'hc0, 8'h05},
              (s == SRC_USB) ? md == 2 : md == 1);
        cmp_q(DST_USB, '{8'hc0, 8'h05},
              s != SRC_USB && md == 2);
      end
    usb_adapter_on <= 1'b0;
    $display("test forwarding paths done");
  endtask

  // Two sources race for the serial output; a beat clock cuts in
  task automatic t_merge;
    thru_on <= 1'b1;
    clr;
    fork
      send_msg(SRC_INT, '{8'h90, 8'h3c, 8'h7f});
      send_msg(SRC_FOOT, '{8'hb0, 8'h01, 8'h02});
      begin
        @(posedge clk_sys);
        send_msg(SRC_SER, '{8'hf8});
      end
    join
    drain;
    cmp_q(DST_SER, '{8'h90, 8'hf8, 8'h3c, 8'h7f, 8'hb0, 8'h01,
                     8'h02}, 1);
    thru_on <= 1'b0;
    $display("test merge done");
  endtask

  // Enable low must hold a waiting byte; repeats would show as extras
  task automatic t_freeze;
    clr;
    ce <= 1'b0;
    src_in[SRC_INT] <= {1'b1, 8'hf6};
    repeat (5) begin
      @(posedge clk_sys);
      check("ready frozen", {31'h0, src_ready[SRC_INT]}, 32'h0);
    end
    ce <= 1'b1;
    send_msg(SRC_INT, '{8'hf6});
    drain;
    cmp_q(DST_FOOT, '{8'hf6}, 1);
    $display("test clock enable done");
  endtask

  // Three sources with both settings on; running status and a sysex
  // frame must each pass whole, in priority order
  task automatic t_both;
    thru_on <= 1'b1;
    usb_adapter_on <= 1'b1;
    clr;
    fork
      send_msg(SRC_USB, '{8'hc0, 8'h05});
      send_msg(SRC_SER, '{8'h90, 8'h3c, 8'h7f, 8'h3e, 8'h00});
      send_msg(SRC_FOOT, '{8'hf0, 8'h7d, 8'hf7});
    join
    drain;
    cmp_q(DST_SER, '{8'hc0, 8'h05, 8'h90, 8'h3c, 8'h7f, 8'h3e, 8'h00,
                     8'hf0, 8'h7d, 8'hf7}, 1);
    cmp_q(DST_PROC, '{8'hc0, 8'h05, 8'h90, 8'h3c, 8'h7f, 8'h3e, 8'h00,
                      8'hf0, 8'h7d, 8'hf7}, 1);
    cmp_q(DST_USB, '{8'h90, 8'h3c, 8'h7f, 8'h3e, 8'h00, 8'hf0, 8'h7d,
                     8'hf7}, 1);
    thru_on <= 1'b0;
    usb_adapter_on <= 1'b0;
    $display("test both settings done");
  endtask

  task automatic t_tempo;
    repeat (TL + 50) @(posedge clk_sys);
    send_msg(SRC_SER, '{8'hf8});
    t1 = tk;
    repeat (36) @(posedge clk_sys);
    send_msg(SRC_SER, '{8'hf8});
    repeat (4) @(posedge clk_sys);
    check("beat interval", beat_interval, 32'(tk - t1));
    check("tempo sync", {31'h0, tempo_sync}, 32'h1);
    repeat (TL - 20) @(posedge clk_sys);
    check("sync held", {31'h0, tempo_sync}, 32'h1);
    repeat (40) @(posedge clk_sys);
    check("sync lost", {31'h0, tempo_sync}, 32'h0);
    $display("test tempo done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    $display("watchdog expired");
    complete_run;
  end

  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    thru_on = 1'b0;
    usb_adapter_on = 1'b0;
    int_dump = 1'b0;
    int_dump_usb = 1'b0;
    slow = 1'b0;
    src_in = '0;
    n_fail = 0;
    num_checks = 0;
    cyc = 0;
    repeat (16) @(posedge clk_sys);
    check("valid in reset", {31'h0, any_v}, 32'h0);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    t_internal;
    t_dump;
    t_paths;
    t_merge;
    t_freeze;
    t_both;
    t_tempo;
    complete_run;
  end
endmodule // testbench
